// ===== src/ams_cfg.svh
// Register map, field positions, reset values and timing counts of the sample sequencer
`ifndef AMS_CFG_SVH
`define AMS_CFG_SVH

// ==========================================================================
// Register byte addresses
`define AMS_REG_SEQ_CTRL    16'h0000
`define AMS_REG_SEQ_STATUS  16'h0004
`define AMS_REG_AFE_DIFF    16'h210C
`define AMS_REG_ADC_BIAS    16'h2200

// ==========================================================================
// Field positions
`define AMS_CTRL_COUNT_LSB  0
`define AMS_CTRL_COUNT_MSB  3
`define AMS_CTRL_FLEN_LSB   4
`define AMS_CTRL_FLEN_MSB   5
`define AMS_CTRL_PRE_BIT    6
`define AMS_CTRL_DIFFB_BIT  7
`define AMS_CTRL_RMT_BIT    8
`define AMS_DIFFA_BIT       4
`define AMS_ADC_DIV_BIT     5

// ==========================================================================
// Reset values and the 22-bit filter length code
`define AMS_RST_COUNT       4'h3
`define AMS_RST_FLEN        2'h1
`define AMS_FLEN_22BIT      2'h2

// ==========================================================================
// Frame timing in slow clock periods, and the result shift in bits
`define AMS_FRAME_TICKS     4'hD
`define AMS_REMOTE_TICK     4'h7
`define AMS_RESULT_SHIFT    9

// ==========================================================================
// Compute-engine RAM slots
`define AMS_SLOT_IA         4'h0
`define AMS_SLOT_IB         4'h2
`define AMS_SLOT_VB         4'h9
`define AMS_SLOT_VA         4'hA

`endif

// ===== src/ams_pkg.sv
// Types shared by the sample sequencer modules
package ams_pkg;

    // ======================================================================
    // Inputs the multiplexer can apply to the converter
    typedef enum logic [2:0] {
        AMS_IN_IA,
        AMS_IN_VA,
        AMS_IN_IB,
        AMS_IN_VB,
        AMS_IN_NONE
    } ams_input_e;

    // ======================================================================
    // Conversion sequencer states
    typedef enum logic [1:0] {
        AMS_SEQ_IDLE,
        AMS_SEQ_CONV
    } ams_seq_e;

    typedef logic [21:0] ams_result_t;

endpackage : ams_pkg

// ===== src/ams_dec_if.sv
// Handshake between the sequencer and one decimation filter
`timescale 1ns/1ps
interface ams_dec_if;
    import ams_pkg::*;

    logic        start;
    logic        mod_bit;
    logic        len22;
    logic        done;
    ams_result_t result;

    modport seq (
        output start,
        output mod_bit,
        output len22,
        input  done,
        input  result
    );

    modport dec (
        input  start,
        input  mod_bit,
        input  len22,
        output done,
        output result
    );
endinterface : ams_dec_if

// ===== src/ams_decimator.sv
// Second-order decimation filter for a one-bit modulator stream
`timescale 1ns/1ps
module ams_decimator #(
    parameter int CONV_CYCLES = 600
) (
    input  wire logic hclk,
    input  wire logic hresetn,
    ams_dec_if.dec    dif
);
    import ams_pkg::*;

    logic              run_ff;
    logic [15:0]       cnt_ff;
    logic signed [31:0] acc1_ff;
    logic signed [31:0] acc2_ff;
    logic              done_ff;
    ams_result_t       result_ff;
    logic signed [31:0] step;
    logic signed [31:0] nxt_acc1;

    // Clip to the signed width selected by the filter length
    function automatic ams_result_t clip(input logic signed [31:0] v, input logic wide);
        logic signed [31:0] hi;
        logic signed [31:0] lo;
        hi = wide ? 32'sh001FFFFF : 32'sh000FFFFF;
        lo = wide ? -32'sh00200000 : -32'sh00100000;
        if (v > hi) begin
            v = hi;
        end else if (v < lo) begin
            v = lo;
        end
        clip = v[21:0];
    endfunction : clip

    assign step     = dif.mod_bit ? 32'sh00000001 : -32'sh00000001;
    assign nxt_acc1 = acc1_ff + step;

    // ======================================================================
    // Integrators and window counter
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            run_ff  <= 1'b0;
            cnt_ff  <= 16'h0000;
            acc1_ff <= 32'sh00000000;
            acc2_ff <= 32'sh00000000;
        end else if (dif.start) begin
            run_ff  <= 1'b1;
            cnt_ff  <= 16'h0000;
            acc1_ff <= 32'sh00000000;
            acc2_ff <= 32'sh00000000;
        end else if (run_ff) begin
            acc1_ff <= nxt_acc1;
            acc2_ff <= acc2_ff + nxt_acc1;
            cnt_ff  <= cnt_ff + 16'h0001;
            if (cnt_ff == 16'(CONV_CYCLES - 1)) begin
                run_ff <= 1'b0;
            end
        end
    end

    // ======================================================================
    // Result and end-of-conversion pulse
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            done_ff   <= 1'b0;
            result_ff <= 22'h000000;
        end else begin
            done_ff <= run_ff && !dif.start && (cnt_ff == 16'(CONV_CYCLES - 1));
            if (run_ff && !dif.start && (cnt_ff == 16'(CONV_CYCLES - 1))) begin
                result_ff <= clip(acc2_ff + nxt_acc1, dif.len22);
            end
        end
    end

    assign dif.done   = done_ff;
    assign dif.result = result_ff;
endmodule : ams_decimator

// ===== src/ams_sequencer.sv
// Input multiplexer sequencer with conversion control, result store and AHB-Lite registers
// How it works
// - Each frame starts at state 1, one state per conversion, up to the count.
// - Small variant converts up to three inputs; large variant adds voltage B.
// - A frame lasts exactly thirteen slow clock periods.
// - With the remote sensor on, the local third slot result is dropped.
// - Remote current is sampled in the frame's second half at a fixed tick.
// - Result width is 21 bits for filter length 1, 22 bits for 2.
// - The sequencer starts each conversion and stores its result by state.
// - Results are stored LSB justified, shifted left nine bits, sign extended.
// - Preamp enable gives gain eight on current A; off means unity and powered down.
// - Current A differential bit lives at bit 4 of 0x210C, preamp works either way.
// - Preamp and converter bias follow the divide bit at bit 5 of 0x2200.
// - Current A goes to slot 0; slot 1 is never written.
// - Current B, local or remote, goes to slot 2; slot 3 is never written.
// - Voltage A goes to slot 10.
// - Voltage B, large variant only, goes to slot 9.
// - Remote enable turns the current B pins into a digital link.
// - Remote stream is decimated each frame and written in a RAM access slot.
`timescale 1ns/1ps
`include "ams_cfg.svh"
module ams_sequencer #(
    parameter bit LARGE_VARIANT = 1'b1,
    parameter int CONV_CYCLES   = 600
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [15:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    input  wire logic        slow_clock_32k,
    input  wire logic        adc_mod_bit,
    input  wire logic        remote_mod_bit,
    output ams_pkg::ams_input_e mux_sel,
    output logic             frame_start,
    output logic             preamp_gain8_en,
    output logic             preamp_power_down,
    output logic             current_a_diff_enable,
    output logic             current_b_diff_enable,
    output logic             current_b_digital_link,
    output logic             bias_reduced,
    input  wire logic        ram_grant,
    output logic             ram_we,
    output logic [3:0]       ram_addr,
    output logic [31:0]      ram_wdata
);
    import ams_pkg::*;
    localparam logic [3:0] MAX_STATES = LARGE_VARIANT ? 4'h4 : 4'h3;

    // ======================================================================
    // Register storage
    logic [3:0]  sw_count_ff;
    logic [1:0]  sw_flen_ff;
    logic        sw_pre_ff;
    logic        sw_diffb_ff;
    logic        sw_rmt_ff;
    logic        sw_diffa_ff;
    logic        sw_adc_div_ff;
    // Frame-latched copies that actually steer the front end
    logic [3:0]  fr_count_ff;
    logic        fr_len22_ff;
    logic        fr_pre_ff;
    logic        fr_diffa_ff;
    logic        fr_diffb_ff;
    logic        fr_rmt_ff;
    logic        fr_adc_div_ff;
    logic        slow_prev_ff;
    logic [3:0]  tick_ff;
    logic [15:0] frame_cnt_ff;
    ams_seq_e    seq_ff;
    logic [2:0]  state_ff;
    logic        loc_start_ff;
    logic        rmt_start_ff;
    logic        loc_pend_ff;
    logic [3:0]  loc_addr_ff;
    logic [31:0] loc_data_ff;
    logic        rmt_pend_ff;
    logic [31:0] rmt_data_ff;
    logic        ram_we_ff;
    logic [3:0]  ram_addr_ff;
    logic [31:0] ram_wdata_ff;
    logic        ap_wr_ff;
    logic [15:0] ap_addr_ff;
    logic [31:0] hrdata_ff;
    logic        slow_rise;
    logic        frame_edge;
    logic        take_ap;
    logic [3:0]  clamped_count;
    logic        loc_store;
    logic        load_loc;
    logic        load_rmt;
    ams_dec_if loc_if ();
    ams_dec_if rmt_if ();

    // ======================================================================
    // Helpers
    function automatic ams_input_e input_for_state(input logic [2:0] st);
        unique case (st)
            3'h1:    input_for_state = AMS_IN_IA;
            3'h2:    input_for_state = AMS_IN_VA;
            3'h3:    input_for_state = AMS_IN_IB;
            3'h4:    input_for_state = AMS_IN_VB;
            default: input_for_state = AMS_IN_NONE;
        endcase
    endfunction : input_for_state
    function automatic logic [3:0] slot_for_input(input ams_input_e in);
        unique case (in)
            AMS_IN_IA: slot_for_input = `AMS_SLOT_IA;
            AMS_IN_IB: slot_for_input = `AMS_SLOT_IB;
            AMS_IN_VA: slot_for_input = `AMS_SLOT_VA;
            AMS_IN_VB: slot_for_input = `AMS_SLOT_VB;
            default:   slot_for_input = `AMS_SLOT_IA;
        endcase
    endfunction : slot_for_input
    // Sign extend then place at bit 9; 22 + 9 bits still fit the word
    function automatic logic [31:0] place(input ams_result_t r);
        logic [31:0] ext;
        ext = {{10{r[21]}}, r};
        place = ext << `AMS_RESULT_SHIFT;
    endfunction : place

    // ======================================================================
    // AHB-Lite slave: zero wait states, always OKAY
    assign take_ap   = hsel && htrans[1] && hready;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_ff;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_wr_ff   <= 1'b0;
            ap_addr_ff <= 16'h0000;
        end else begin
            ap_wr_ff   <= take_ap && hwrite;
            ap_addr_ff <= haddr;
        end
    end
    // Read data is sampled in the address phase, so a read right after a
    // write to the same register shows the old value
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_ff <= 32'h00000000;
        end else if (take_ap && !hwrite) begin
            hrdata_ff <= 32'h00000000;
            unique case (haddr)
                `AMS_REG_SEQ_CTRL: begin
                    hrdata_ff[`AMS_CTRL_COUNT_MSB:`AMS_CTRL_COUNT_LSB] <= sw_count_ff;
                    hrdata_ff[`AMS_CTRL_FLEN_MSB:`AMS_CTRL_FLEN_LSB]   <= sw_flen_ff;
                    hrdata_ff[`AMS_CTRL_PRE_BIT]   <= sw_pre_ff;
                    hrdata_ff[`AMS_CTRL_DIFFB_BIT] <= sw_diffb_ff;
                    hrdata_ff[`AMS_CTRL_RMT_BIT]   <= sw_rmt_ff;
                end
                `AMS_REG_SEQ_STATUS: begin
                    hrdata_ff[2:0]   <= state_ff;
                    hrdata_ff[3]     <= (seq_ff == AMS_SEQ_CONV);
                    hrdata_ff[4]     <= rmt_pend_ff;
                    hrdata_ff[11:8]  <= tick_ff;
                    hrdata_ff[31:16] <= frame_cnt_ff;
                end
                `AMS_REG_AFE_DIFF: hrdata_ff[`AMS_DIFFA_BIT] <= sw_diffa_ff;
                `AMS_REG_ADC_BIAS: hrdata_ff[`AMS_ADC_DIV_BIT] <= sw_adc_div_ff;
                default:           hrdata_ff <= 32'h00000000;
            endcase
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sw_count_ff   <= `AMS_RST_COUNT;
            sw_flen_ff    <= `AMS_RST_FLEN;
            sw_pre_ff     <= 1'b0;
            sw_diffb_ff   <= 1'b0;
            sw_rmt_ff     <= 1'b0;
            sw_diffa_ff   <= 1'b0;
            sw_adc_div_ff <= 1'b0;
        end else if (ap_wr_ff) begin
            unique case (ap_addr_ff)
                `AMS_REG_SEQ_CTRL: begin
                    sw_count_ff <= hwdata[`AMS_CTRL_COUNT_MSB:`AMS_CTRL_COUNT_LSB];
                    sw_flen_ff  <= hwdata[`AMS_CTRL_FLEN_MSB:`AMS_CTRL_FLEN_LSB];
                    sw_pre_ff   <= hwdata[`AMS_CTRL_PRE_BIT];
                    sw_diffb_ff <= hwdata[`AMS_CTRL_DIFFB_BIT];
                    sw_rmt_ff   <= hwdata[`AMS_CTRL_RMT_BIT];
                end
                `AMS_REG_AFE_DIFF: sw_diffa_ff   <= hwdata[`AMS_DIFFA_BIT];
                `AMS_REG_ADC_BIAS: sw_adc_div_ff <= hwdata[`AMS_ADC_DIV_BIT];
                default: ;
            endcase
        end
    end

    // ======================================================================
    // Frame timing from the slow clock
    assign slow_rise  = slow_clock_32k && !slow_prev_ff;
    assign frame_edge = slow_rise && (tick_ff == `AMS_FRAME_TICKS - 4'h1);
    assign frame_start = frame_edge;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            slow_prev_ff <= 1'b0;
            tick_ff      <= 4'h0;
            frame_cnt_ff <= 16'h0000;
        end else begin
            slow_prev_ff <= slow_clock_32k;
            if (frame_edge) begin
                tick_ff      <= 4'h0;
                frame_cnt_ff <= frame_cnt_ff + 16'h0001;
            end else if (slow_rise) begin
                tick_ff <= tick_ff + 4'h1;
            end
        end
    end

    // ======================================================================
    // Configuration taken only at frame start
    always_comb begin
        clamped_count = sw_count_ff;
        if (sw_count_ff > MAX_STATES) begin
            clamped_count = MAX_STATES;
        end else if (sw_count_ff == 4'h0) begin
            clamped_count = 4'h1;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fr_count_ff   <= `AMS_RST_COUNT;
            fr_len22_ff   <= 1'b0;
            fr_pre_ff     <= 1'b0;
            fr_diffa_ff   <= 1'b0;
            fr_diffb_ff   <= 1'b0;
            fr_rmt_ff     <= 1'b0;
            fr_adc_div_ff <= 1'b0;
        end else if (frame_edge) begin
            fr_count_ff   <= clamped_count;
            fr_len22_ff   <= (sw_flen_ff == `AMS_FLEN_22BIT);
            fr_pre_ff     <= sw_pre_ff;
            fr_diffa_ff   <= sw_diffa_ff;
            fr_diffb_ff   <= sw_diffb_ff;
            fr_rmt_ff     <= sw_rmt_ff;
            fr_adc_div_ff <= sw_adc_div_ff;
        end
    end
    assign preamp_gain8_en        = fr_pre_ff;
    assign preamp_power_down      = !fr_pre_ff;
    assign current_a_diff_enable  = fr_diffa_ff;
    assign current_b_diff_enable  = fr_diffb_ff && !fr_rmt_ff;
    assign current_b_digital_link = fr_rmt_ff;
    assign bias_reduced           = fr_adc_div_ff;

    // ======================================================================
    // Conversion sequencer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            seq_ff       <= AMS_SEQ_IDLE;
            state_ff     <= 3'h0;
            loc_start_ff <= 1'b0;
        end else begin
            loc_start_ff <= 1'b0;
            if (frame_edge) begin
                seq_ff       <= AMS_SEQ_CONV;
                state_ff     <= 3'h1;
                loc_start_ff <= 1'b1;
            end else begin
                unique case (seq_ff)
                    AMS_SEQ_IDLE: ;
                    AMS_SEQ_CONV: begin
                        if (loc_if.done) begin
                            if ({1'b0, state_ff} < fr_count_ff) begin
                                state_ff     <= state_ff + 3'h1;
                                loc_start_ff <= 1'b1;
                            end else begin
                                seq_ff   <= AMS_SEQ_IDLE;
                                state_ff <= 3'h0;
                            end
                        end
                    end
                endcase
            end
        end
    end
    assign mux_sel = (seq_ff == AMS_SEQ_CONV) ? input_for_state(state_ff) : AMS_IN_NONE;
    // The third slot still converts with the remote sensor on, but is dropped
    assign loc_store = loc_if.done && (seq_ff == AMS_SEQ_CONV) &&
                       !(fr_rmt_ff && input_for_state(state_ff) == AMS_IN_IB);
    // Remote stream window opens at a fixed tick in the second half
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rmt_start_ff <= 1'b0;
        end else begin
            rmt_start_ff <= fr_rmt_ff && slow_rise &&
                            (tick_ff == `AMS_REMOTE_TICK - 4'h1);
        end
    end
    assign loc_if.start   = loc_start_ff;
    assign loc_if.mod_bit = adc_mod_bit;
    assign loc_if.len22   = fr_len22_ff;
    assign rmt_if.start   = rmt_start_ff;
    assign rmt_if.mod_bit = remote_mod_bit;
    assign rmt_if.len22   = fr_len22_ff;
    ams_decimator #(.CONV_CYCLES(CONV_CYCLES)) u_loc_dec (
        .hclk(hclk), .hresetn(hresetn), .dif(loc_if.dec));
    ams_decimator #(.CONV_CYCLES(CONV_CYCLES)) u_rmt_dec (
        .hclk(hclk), .hresetn(hresetn), .dif(rmt_if.dec));

    // ======================================================================
    // RAM write port; local results first, a new result wins over a load
    assign load_loc = !ram_we_ff && loc_pend_ff;
    assign load_rmt = !ram_we_ff && !loc_pend_ff && rmt_pend_ff;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            loc_pend_ff <= 1'b0;
            loc_addr_ff <= 4'h0;
            loc_data_ff <= 32'h00000000;
        end else if (loc_store) begin
            loc_pend_ff <= 1'b1;
            loc_addr_ff <= slot_for_input(input_for_state(state_ff));
            loc_data_ff <= place(loc_if.result);
        end else if (load_loc) begin
            loc_pend_ff <= 1'b0;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rmt_pend_ff <= 1'b0;
            rmt_data_ff <= 32'h00000000;
        end else if (rmt_if.done) begin
            rmt_pend_ff <= 1'b1;
            rmt_data_ff <= place(rmt_if.result);
        end else if (load_rmt) begin
            rmt_pend_ff <= 1'b0;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ram_we_ff    <= 1'b0;
            ram_addr_ff  <= 4'h0;
            ram_wdata_ff <= 32'h00000000;
        end else if (ram_we_ff) begin
            if (ram_grant) begin
                ram_we_ff <= 1'b0;
            end
        end else if (load_loc) begin
            ram_we_ff    <= 1'b1;
            ram_addr_ff  <= loc_addr_ff;
            ram_wdata_ff <= loc_data_ff;
        end else if (load_rmt) begin
            ram_we_ff    <= 1'b1;
            ram_addr_ff  <= `AMS_SLOT_IB;
            ram_wdata_ff <= rmt_data_ff;
        end
    end
    assign ram_we    = ram_we_ff;
    assign ram_addr  = ram_addr_ff;
    assign ram_wdata = ram_wdata_ff;
endmodule : ams_sequencer

// ===== verification/ams_seq_properties.sv
// Port-level property checker for the sample sequencer
`timescale 1ns/1ps
module ams_seq_properties (
    input logic                hclk,
    input logic                hresetn,
    input logic                slow_clock_32k,
    input ams_pkg::ams_input_e mux_sel,
    input logic                frame_start,
    input logic                preamp_gain8_en,
    input logic                preamp_power_down,
    input logic                current_a_diff_enable,
    input logic                current_b_digital_link,
    input logic                bias_reduced,
    input logic                ram_grant,
    input logic                ram_we,
    input logic [3:0]          ram_addr,
    input logic [31:0]         ram_wdata
);
    import ams_pkg::*;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // ==========================================================
    // Raw slow rises since the last boundary; tolerant of sync delay
    logic       slow_q;
    logic [4:0] rises;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            slow_q <= 1'b0;
            rises  <= 5'h00;
        end else begin
            slow_q <= slow_clock_32k;
            rises  <= frame_start ? 5'h00 : rises + {4'h0, slow_clock_32k & ~slow_q};
        end
    end
    AST_FRAME_13: assert property (frame_start |->
        (rises + {4'h0, slow_clock_32k & ~slow_q}) == 5'h0D)
        else $error("frame length");
    AST_FS_PULSE: assert property (frame_start |=> !frame_start)
        else $error("boundary pulse");
    AST_FS_IA: assert property (frame_start |=> mux_sel == AMS_IN_IA)
        else $error("first state");
    AST_WE_HOLD: assert property (ram_we && !ram_grant |=> ram_we && $stable(ram_addr)
        && $stable(ram_wdata))
        else $error("write dropped");
    AST_SLOTS: assert property (ram_we |-> ram_addr inside {4'h0, 4'h2, 4'h9, 4'hA})
        else $error("bad slot");
    AST_SHIFT: assert property (ram_we |-> ram_wdata[8:0] == 9'h000
        && ram_wdata[31] == ram_wdata[30])
        else $error("result alignment");
    AST_CFG_HOLD: assert property (!frame_start |=> $stable({preamp_gain8_en,
        current_a_diff_enable, current_b_digital_link, bias_reduced}))
        else $error("config changed in frame");
    AST_PRE: assert property (preamp_gain8_en == !preamp_power_down)
        else $error("preamp power");
    cover property (frame_start);
    cover property (ram_we && ram_grant && ram_addr == 4'h9);
    cover property (current_b_digital_link && ram_we && ram_grant);
endmodule : ams_seq_properties

bind ams_sequencer ams_seq_properties u_prop (.*);

// ===== verification/ams_afe_model.sv
// Converter and compute-engine RAM stand-in for the sample sequencer bench
`timescale 1ns/1ps
module ams_afe_model #(
    parameter int SLOW_P = 60
) (
    input  wire logic hclk,
    input  wire logic hresetn,
    output logic      slow_clock_32k,
    output logic      adc_mod_bit,
    output logic      remote_mod_bit,
    output logic      ram_grant
);
    // ==========================================================
    // Free-running slow clock, modulator streams, stalling RAM slot
    int         cnt  = 0;
    logic [7:0] lfsr = 8'h5A;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt  <= 0;
            lfsr <= 8'h5A;
        end else begin
            cnt  <= (cnt == SLOW_P - 1) ? 0 : cnt + 1;
            lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
        end
    end
    assign slow_clock_32k = (cnt >= SLOW_P / 2);
    assign adc_mod_bit    = lfsr[0];
    assign remote_mod_bit = lfsr[3];
    // One grant in four, locked to the slow clock so write times repeat
    assign ram_grant      = (cnt[1:0] == 2'h3);
endmodule : ams_afe_model

// ===== verification/tb_afe_mux_sample_sequencer.sv
// Self-checking bench for the sample sequencer
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_count++; \
    $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module tb_afe_mux_sample_sequencer;
    import ams_pkg::*;
    localparam int     SLOW_P   = 60;
    localparam longint FRAME_NS = 13 * SLOW_P * 100;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [15:0] haddr = 16'h0000;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0, hrdata, ram_wdata;
    logic        hreadyout, hresp, frame_start, ram_we, ram_grant, slow_clock_32k;
    logic        adc_mod_bit, remote_mod_bit, preamp_gain8_en, preamp_power_down;
    logic        current_a_diff_enable, current_b_diff_enable, current_b_digital_link;
    logic        bias_reduced;
    logic [3:0]  ram_addr;
    ams_input_e  mux_sel;
    int          err_count = 0, comparisons = 0;
    logic [3:0]  wq[$];
    longint      tq[$];
    longint      t0, d;

    always #50 hclk = ~hclk;

    ams_sequencer #(.LARGE_VARIANT(1'b1), .CONV_CYCLES(20)) dut_u (.hready(hreadyout), .*);
    ams_afe_model #(.SLOW_P(SLOW_P)) afe_u (.*);

    always @(posedge hclk) if (ram_we && ram_grant) begin
        wq.push_back(ram_addr);
        tq.push_back($time);
        `CHK(ram_wdata[31:29], {3{ram_wdata[29]}})
    end

    // ==========================================================
    // Bus and frame helpers
    task automatic ahb(input logic w, input logic [15:0] a, input logic [31:0] wd,
                       output logic [31:0] r);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask : ahb

    task automatic wfs;
        do @(posedge hclk); while (frame_start !== 1'b1);
    endtask : wfs

    // Skips the frame in progress, then logs the writes of one whole frame
    task automatic chk_frame(input logic [15:0] e, input int n);
        wfs();
        t0 = $time;
        wq.delete();
        tq.delete();
        wfs();
        `CHK($time - t0, FRAME_NS)
        `CHK(wq.size(), n)
        for (int i = 0; i < n; i++) `CHK(wq[i], e[i*4 +: 4])
    endtask : chk_frame

    // ==========================================================
    // Scenarios
    task automatic t_regs;
        logic [31:0] r;
        ahb(1'b0, 16'h0000, 32'h0, r);
        `CHK({hresp, r}, 33'h13)
        ahb(1'b1, 16'h0100, 32'hFFFFFFFF, r);
        ahb(1'b0, 16'h0100, 32'h0, r);
        `CHK(r, 32'h0)
        $display("t_regs done");
    endtask : t_regs

    task automatic t_four;
        logic [31:0] r;
        chk_frame(16'h02A0, 3);
        ahb(1'b1, 16'h0000, 32'h1F, r);
        chk_frame(16'h92A0, 4);
        $display("t_four done");
    endtask : t_four

    task automatic t_remote;
        logic [31:0] r;
        ahb(1'b1, 16'h0000, 32'h113, r);
        chk_frame(16'h02A0, 3);
        `CHK(tq[2] - t0 > FRAME_NS / 2, 1'b1)
        `CHK(current_b_digital_link, 1'b1)
        `CHK(current_b_diff_enable, 1'b0)
        d = tq[2] - t0;
        chk_frame(16'h02A0, 3);
        `CHK(tq[2] - t0, d)
        $display("t_remote done");
    endtask : t_remote

    task automatic t_front;
        logic [31:0] r;
        ahb(1'b1, 16'h0000, 32'hD3, r);
        ahb(1'b1, 16'h210C, 32'h10, r);
        ahb(1'b1, 16'h2200, 32'h20, r);
        `CHK(preamp_gain8_en, 1'b0)
        wfs();
        @(posedge hclk);
        `CHK({preamp_gain8_en, preamp_power_down}, 2'h2)
        `CHK(current_a_diff_enable, 1'b1)
        `CHK({current_b_diff_enable, current_b_digital_link}, 2'h2)
        `CHK(bias_reduced, 1'b1)
        ahb(1'b0, 16'h210C, 32'h0, r);
        `CHK(r, 32'h10)
        $display("t_front done");
    endtask : t_front

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : test_done

    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs();
        t_four();
        t_remote();
        t_front();
        test_done();
    end

    initial begin
        repeat (20000) @(posedge hclk);
        err_count++;
        test_done();
    end
endmodule : tb_afe_mux_sample_sequencer
